// ==== pkg/adc_ctl_pkg.sv ====
// constants, field layouts, encodings and states of the converter control block
// assumes an 8-bit register port on the system clock and an external analog core
package adc_ctl_pkg;
    localparam logic [1:0] ADDR_CONV_CTRL   = 2'h0;  // conversion_control
    localparam logic [1:0] ADDR_TRIG_REF    = 2'h1;  // trigger_and_reference_select
    localparam logic [1:0] ADDR_RESULT_HIGH = 2'h2;  // result_high
    localparam logic [1:0] ADDR_RESULT_LOW  = 2'h3;  // result_low
    localparam int BIT_ON   = 0;                     // converter_on
    localparam int BIT_GO   = 1;                     // start/busy
    localparam int CHS_LSB  = 2;                     // input_channel_select low bit
    localparam int TRIG_BIT = 7;                     // trigger_source_select
    localparam int PREF_LSB = 2;                     // positive_ref_select low bit
    localparam int NREF_LSB = 0;                     // negative_ref_select low bit
    localparam logic [7:0] CONV_CTRL_MASK = 8'h7f;   // writable bits of conversion_control
    localparam logic [7:0] TRIG_REF_MASK  = 8'h8f;   // writable bits of second register
    localparam logic [7:0] REG_RESET      = 8'h00;   // reset value of both registers
    localparam logic [4:0] CH_LAST_EXT    = 5'h1b;   // last external input
    localparam logic [4:0] CH_RESERVED    = 5'h1c;
    localparam logic [4:0] CH_CHARGE      = 5'h1d;
    localparam logic [4:0] CH_DAC         = 5'h1e;
    localparam logic [4:0] CH_FIXED_REF   = 5'h1f;
    localparam logic [1:0] PREF_SUPPLY = 2'h0;
    localparam logic [1:0] PREF_PIN    = 2'h1;
    localparam logic [1:0] PREF_FIXED  = 2'h2;
    localparam logic [1:0] NREF_GROUND = 2'h0;
    localparam logic [1:0] NREF_PIN    = 2'h1;
    localparam int START_DELAY_CYC = 4;              // one instruction cycle of four clocks
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,                            // no conversion
        ST_DELAY = 2'b01,                            // rc start delay
        ST_CONV  = 2'b10                             // core converting
    } conv_state_t;
endpackage : adc_ctl_pkg

// ==== logic/adc_trigger_sleep_control.sv ====
// converter control: enable, start/busy, channel, references, triggers, sleep
// assumes the analog core reports completion with a one-cycle done pulse and result
//
// Local design decisions: the plain strobed port and the placing of the registers.
module adc_trigger_sleep_control #(
    parameter int DELAY_CYC = adc_ctl_pkg::START_DELAY_CYC  // rc start delay in clocks
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    clk_en,
    // register port
    input  wire logic [1:0]              addr,
    input  wire logic [7:0]              wdata,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    output logic      [7:0]              rdata,
    // power and system
    input  wire logic                    module_disable,  // converter_module_disable
    input  wire logic                    sleep_mode,      // device asleep
    input  wire logic                    irq_enable,      // converter interrupt enable
    input  wire logic                    rc_clock_sel,    // rc oscillator is conversion clock
    // trigger sources, asynchronous
    input  wire logic                    compare_trigger,
    input  wire logic                    charge_trigger,
    // analog core
    input  wire logic                    core_done,
    input  wire logic [9:0]              core_result,
    output logic                         core_power,
    output logic                         core_start,
    output logic                         core_abort,
    output logic                         core_clk_en,
    output logic [4:0]                   core_channel,
    output logic                         sel_charge_unit,
    output logic                         sel_dac,
    output logic                         sel_fixed_ref,
    output logic [1:0]                   pref_route,
    output logic                         nref_route,
    // events
    output logic                         done_flag_set,   // conversion_done_flag pulse
    output logic                         wake_request
);
    import adc_ctl_pkg::*;

    // elaboration check of the delay count
    if (DELAY_CYC < 1 || DELAY_CYC > 255) begin : g_bad_delay
        $error("DELAY_CYC out of range");
    end

    // whole block state, one register
    typedef struct packed {
        logic [7:0]  ctrl;        // conversion_control
        logic [7:0]  trig;        // trigger_and_reference_select
        logic [9:0]  result;      // result pair
        conv_state_t st;
        logic [7:0]  cnt;         // start delay count
        logic [1:0]  cmp_sync;    // synchroniser
        logic [1:0]  chg_sync;
        logic        trig_last;   // edge detect of selected trigger
        logic        powered_off; // sleep shut-off, enable stays set
        logic [7:0]  rdata;
        logic        start;
        logic        abort;
        logic        done_set;
        logic        wake;
        logic        power;
        logic        clk_on;
        logic [4:0]  chan;
        logic        s_chg;
        logic        s_dac;
        logic        s_fix;
        logic [1:0]  pref;
        logic        nref;
    } state_t;

    // registered state and its next value
    state_t state_reg;
    state_t state_next;

    // reference decode, reserved codes fall back
    function automatic logic [1:0] pref_decode(input logic [1:0] code);
        pref_decode = (code == PREF_PIN || code == PREF_FIXED) ? code : PREF_SUPPLY;
    endfunction : pref_decode

    // negative reference decode
    function automatic logic nref_decode(input logic [1:0] code);
        nref_decode = (code == NREF_PIN);
    endfunction : nref_decode

    // combinational helpers
    logic trig_sel;     // selected synchronised trigger level
    logic trig_edge;
    logic sw_go;
    logic sw_stop;
    logic busy;
    logic [4:0] ch;

    // next-state logic
    always_comb begin
        // hold by default, shift the synchronisers
        state_next = state_reg;
        state_next.cmp_sync = {state_reg.cmp_sync[0], compare_trigger};
        state_next.chg_sync = {state_reg.chg_sync[0], charge_trigger};
        // selected trigger and its rising edge
        trig_sel = state_reg.trig[TRIG_BIT] ? state_reg.chg_sync[1]
                                            : state_reg.cmp_sync[1];
        trig_edge = trig_sel && !state_reg.trig_last;
        state_next.trig_last = trig_sel;
        // software strobes on the first register
        busy = state_reg.ctrl[BIT_GO];
        sw_go = wr_en && addr == ADDR_CONV_CTRL && wdata[BIT_GO] && !busy;
        sw_stop = wr_en && addr == ADDR_CONV_CTRL && !wdata[BIT_GO] && busy;
        // event outputs are one-cycle pulses
        state_next.start = 1'b0;
        state_next.abort = 1'b0;
        state_next.done_set = 1'b0;
        state_next.wake = 1'b0;
        // register writes
        if (wr_en && addr == ADDR_CONV_CTRL) begin
            state_next.ctrl = wdata & CONV_CTRL_MASK;
            if (!wdata[BIT_ON]) begin
                state_next.powered_off = 1'b0;
            end
        end
        if (wr_en && addr == ADDR_TRIG_REF) begin
            state_next.trig = wdata & TRIG_REF_MASK;
        end
        // start from software or from an enabled trigger
        if (state_reg.st == ST_IDLE && (sw_go ||
            (trig_edge && state_reg.ctrl[BIT_ON]))) begin
            state_next.ctrl[BIT_GO] = 1'b1;
            state_next.powered_off = 1'b0;
            if (rc_clock_sel) begin
                state_next.st = ST_DELAY;
                state_next.cnt = 8'(DELAY_CYC - 1);
            end else begin
                state_next.st = ST_CONV;
                state_next.start = 1'b1;
            end
        end else if (state_reg.st != ST_IDLE && (sw_stop || !state_reg.ctrl[BIT_ON] ||
                     (sleep_mode && !rc_clock_sel))) begin
            // abort: result unchanged
            state_next.st = ST_IDLE;
            state_next.ctrl[BIT_GO] = 1'b0;
            state_next.abort = 1'b1;
            if (sleep_mode && !rc_clock_sel) begin
                state_next.powered_off = 1'b1;
            end
            // otherwise rc delay countdown
        end else if (state_reg.st == ST_DELAY) begin
            if (state_reg.cnt == 8'h00) begin
                state_next.st = ST_CONV;
                state_next.start = 1'b1;
            end else begin
                state_next.cnt = state_reg.cnt - 8'h01;
            end
            // otherwise completion from the core
        end else if (state_reg.st == ST_CONV && core_done) begin
            state_next.st = ST_IDLE;
            state_next.ctrl[BIT_GO] = 1'b0;
            state_next.result = core_result;
            state_next.done_set = 1'b1;
            if (sleep_mode) begin
                state_next.wake = irq_enable;
                state_next.powered_off = !irq_enable;
            end
        end
        // awake and idle: shut-off ends once enable clears
        if (state_reg.st == ST_IDLE && !sleep_mode) begin
            state_next.powered_off = state_next.powered_off && state_next.ctrl[BIT_ON];
        end
        // outputs
        ch = state_next.ctrl[CHS_LSB +: 5];
        state_next.chan  = (ch <= CH_LAST_EXT) ? ch : 5'h00;
        state_next.s_chg = (ch == CH_CHARGE);
        state_next.s_dac = (ch == CH_DAC);
        state_next.s_fix = (ch == CH_FIXED_REF);
        state_next.pref  = pref_decode(state_next.trig[PREF_LSB +: 2]);
        state_next.nref  = nref_decode(state_next.trig[NREF_LSB +: 2]);
        state_next.power = state_next.ctrl[BIT_ON] && !state_next.powered_off;
        state_next.clk_on = 1'b1;
        // read data, one cycle after the strobe
        state_next.rdata = 8'h00;
        if (rd_en) begin
            unique case (addr)
                ADDR_CONV_CTRL:   state_next.rdata = state_reg.ctrl & CONV_CTRL_MASK;
                ADDR_TRIG_REF:    state_next.rdata = state_reg.trig & TRIG_REF_MASK;
                ADDR_RESULT_HIGH: state_next.rdata = {6'h00, state_reg.result[9:8]};
                ADDR_RESULT_LOW:  state_next.rdata = state_reg.result[7:0];
            endcase
        end
    end

    // state register, module disable acts as reset and gates the clock
    always_ff @(posedge clk) begin
        if (!rst_n || module_disable) begin
            state_reg <= '0;
            state_reg.ctrl <= REG_RESET;
            state_reg.trig <= REG_RESET;
            state_reg.st <= ST_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // every output straight from the state register
    assign rdata           = state_reg.rdata;
    assign core_power      = state_reg.power;
    assign core_start      = state_reg.start;
    assign core_abort      = state_reg.abort;
    assign core_clk_en     = state_reg.clk_on;
    assign core_channel    = state_reg.chan;
    assign sel_charge_unit = state_reg.s_chg;
    assign sel_dac         = state_reg.s_dac;
    assign sel_fixed_ref   = state_reg.s_fix;
    assign pref_route      = state_reg.pref;
    assign nref_route      = state_reg.nref;
    assign done_flag_set   = state_reg.done_set;
    assign wake_request    = state_reg.wake;

    // checks
    // disabled converter never raises busy without a register write
    chk_disable_ignores_trig: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !module_disable && state_reg.st == ST_IDLE && !state_reg.ctrl[BIT_ON] &&
         !wr_en) |=> !state_reg.ctrl[BIT_GO])
        else $error("busy set while converter disabled");

    // core completion with no abort pending
    sequence done_seen;
        clk_en && !module_disable && state_reg.st == ST_CONV && core_done && !sw_stop &&
        state_reg.ctrl[BIT_ON] && !(sleep_mode && !rc_clock_sel);
    endsequence

    // completion clears busy, loads result
    chk_done_clears_busy: assert property (@(posedge clk) disable iff (!rst_n)
        done_seen |=> (!state_reg.ctrl[BIT_GO] && done_flag_set &&
                       state_reg.result == $past(core_result)))
        else $error("completion did not clear busy and load result");

    // software abort keeps the old result
    chk_abort_keeps_result: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !module_disable && sw_stop && state_reg.st != ST_IDLE)
        |=> (state_reg.result == $past(state_reg.result) && core_abort))
        else $error("abort changed result");

    // no start while the rc delay runs
    chk_rc_delay_start: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg.st == ST_DELAY && state_reg.cnt != 8'h00) |-> !core_start)
        else $error("start issued during rc delay");

    // sleep on a non-rc clock aborts and powers off
    chk_sleep_abort_off: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !module_disable && state_reg.st != ST_IDLE && sleep_mode &&
         !rc_clock_sel && !wr_en)
        |=> (!core_power && state_reg.ctrl[BIT_ON] == $past(state_reg.ctrl[BIT_ON])))
        else $error("sleep did not abort and power off");

    // sleep completion with interrupt wakes
    chk_sleep_wake: assert property (@(posedge clk) disable iff (!rst_n)
        (done_seen and (sleep_mode && irq_enable)) |=> wake_request)
        else $error("no wake after sleep conversion");

    // reserved positive code routes the supply
    chk_ref_reserved: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg.trig[PREF_LSB +: 2] == 2'h3) |=> (pref_route == PREF_SUPPLY))
        else $error("reserved positive reference not supply");

    // unimplemented bits stay zero
    chk_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg.ctrl[7] == 1'b0 && state_reg.trig[6:4] == 3'h0))
        else $error("unimplemented bits set");

    // module disable holds the block in reset
    chk_module_disable: assert property (@(posedge clk) disable iff (!rst_n)
        module_disable |=> (state_reg.ctrl == REG_RESET && !core_power))
        else $error("module disable did not reset");

    // trigger start, first step
    sequence trig_start_seen;
        clk_en && !module_disable && state_reg.st == ST_IDLE && trig_edge &&
        state_reg.ctrl[BIT_ON] && !wr_en;
    endsequence

    // trigger start, second step: busy with work under way
    sequence busy_raised;
        state_reg.ctrl[BIT_GO] && state_reg.st != ST_IDLE;
    endsequence

    // enabled trigger raises busy
    chk_trigger_sets_busy: assert property (@(posedge clk) disable iff (!rst_n)
        trig_start_seen |=> busy_raised)
        else $error("trigger did not raise busy");

    // no start without a go write or an edge
    chk_no_spurious_start: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg.st == ST_IDLE && !trig_edge && !sw_go)
        |=> state_reg.st == ST_IDLE)
        else $error("conversion started without an event");

    // non-rc go write starts the core at once
    chk_go_starts_core: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !module_disable && state_reg.st == ST_IDLE && sw_go && !rc_clock_sel)
        |=> core_start)
        else $error("go write did not start the core");

    // rc go write enters the delay
    chk_rc_enters_delay: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !module_disable && state_reg.st == ST_IDLE && sw_go && rc_clock_sel)
        |=> (state_reg.st == ST_DELAY && !core_start))
        else $error("rc start not delayed");

    // start pulse only with busy set
    chk_start_with_busy: assert property (@(posedge clk) disable iff (!rst_n)
        core_start |-> (state_reg.ctrl[BIT_GO] && state_reg.st == ST_CONV))
        else $error("start without busy");

    // busy reads back as one
    chk_busy_reads_one: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !module_disable && rd_en && addr == ADDR_CONV_CTRL &&
         state_reg.ctrl[BIT_GO]) |=> rdata[BIT_GO])
        else $error("busy not read back");

    // enable low keeps the core unpowered
    chk_off_unpowered: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !state_reg.ctrl[BIT_ON] && !(wr_en && addr == ADDR_CONV_CTRL))
        |=> !core_power)
        else $error("core powered while disabled");

    // enable low aborts a conversion
    chk_off_aborts: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !module_disable && state_reg.st != ST_IDLE && !state_reg.ctrl[BIT_ON])
        |=> (state_reg.st == ST_IDLE && core_abort))
        else $error("disable did not abort");

    // no interrupt: shut off, enable kept
    chk_sleep_no_wake: assert property (@(posedge clk) disable iff (!rst_n)
        (done_seen and (sleep_mode && !irq_enable && !wr_en))
        |=> (!wake_request && !core_power && state_reg.ctrl[BIT_ON]))
        else $error("sleep completion did not shut off");

    // completion flag is a single pulse
    chk_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        (done_flag_set && clk_en) |=> !done_flag_set)
        else $error("done flag longer than one cycle");

    // module disable stops the core clock
    chk_clk_gated: assert property (@(posedge clk) disable iff (!rst_n)
        module_disable |=> !core_clk_en)
        else $error("core clock not gated");

    // at most one internal source selected
    chk_channel_route: assert property (@(posedge clk) disable iff (!rst_n)
        ($countones({sel_charge_unit, sel_dac, sel_fixed_ref}) <= 1 &&
         core_channel <= CH_LAST_EXT))
        else $error("channel routing illegal");

    // reserved negative codes route ground
    chk_nref_reserved: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg.trig[NREF_LSB +: 2] != NREF_PIN && !wr_en) |=> !nref_route)
        else $error("reserved negative reference not ground");

    // reserved positive code never routed
    chk_pref_legal: assert property (@(posedge clk) disable iff (!rst_n)
        pref_route != 2'h3)
        else $error("positive reference code illegal");

    // read data zero outside the read cycle
    chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !rd_en) |=> rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule : adc_trigger_sleep_control

// ==== tb/analog_core_model.sv ====
// behavioural model of the analog core behind the converter control block
// assumes a one-cycle start pulse and a one-cycle abort pulse from the block
module analog_core_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control from the block
    input  wire logic       core_start,
    input  wire logic       core_abort,
    input  wire logic       core_power,
    input  wire logic       core_clk_en,
    // bench knobs
    input  wire logic [7:0] conv_len,
    input  wire logic [9:0] res_val,
    // answers
    output logic            core_done,
    output logic [9:0]      core_result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg;   // cycles left
    logic       run_reg;   // conversion in progress
    // count down, drop work on abort, power loss or gated clock
    always_ff @(posedge clk) begin
        core_done <= 1'b0;
        if (!rst_n || !core_clk_en || !core_power || core_abort) begin
            run_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end else if (core_start) begin
            run_reg <= 1'b1;
            cnt_reg <= conv_len;
        end else if (run_reg) begin
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
                run_reg   <= 1'b0;
                core_done <= 1'b1;
            end
        end
    end
    // result only valid beside done, inverted otherwise
    assign core_result = core_done ? res_val : ~res_val;
endmodule : analog_core_model

// ==== tb/adc_trigger_sleep_control_tb.sv ====
// self-checking bench of the converter control block
// assumes the analog core model and the design package are compiled first
module adc_trigger_sleep_control_tb;
    import adc_ctl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, module_disable = 0, sleep_mode = 0;
    logic irq_enable = 0, rc_clock_sel = 0, compare_trigger = 0, charge_trigger = 0;
    logic [1:0] addr = 2'h0, pref_route;
    logic [7:0] wdata = 8'h00, rdata, conv_len = 8'h14, d;
    logic [9:0] res_val = 10'h2a5, core_result;
    logic [4:0] core_channel;
    logic core_done, core_power, core_start, core_abort, core_clk_en, sel_charge_unit;
    logic sel_dac, sel_fixed_ref, nref_route, done_flag_set, wake_request, woke;
    int num_errors = 0, checks_done = 0, n, n0;
    always #10 clk = ~clk;  // 50 MHz
    adc_trigger_sleep_control #(.DELAY_CYC(4)) DUT (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .module_disable(module_disable), .sleep_mode(sleep_mode), .irq_enable(irq_enable),
        .rc_clock_sel(rc_clock_sel), .compare_trigger(compare_trigger),
        .charge_trigger(charge_trigger), .core_done(core_done), .core_result(core_result),
        .core_power(core_power), .core_start(core_start), .core_abort(core_abort),
        .core_clk_en(core_clk_en), .core_channel(core_channel),
        .sel_charge_unit(sel_charge_unit), .sel_dac(sel_dac), .sel_fixed_ref(sel_fixed_ref),
        .pref_route(pref_route), .nref_route(nref_route), .done_flag_set(done_flag_set),
        .wake_request(wake_request));
    analog_core_model core (.clk(clk), .rst_n(rst_n), .core_start(core_start),
        .core_abort(core_abort), .core_power(core_power), .core_clk_en(core_clk_en),
        .conv_len(conv_len), .res_val(res_val), .core_done(core_done),
        .core_result(core_result));
    // compare and count
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one-cycle register write
    task wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk) begin addr <= a; wdata <= v; wr_en <= 1'b1; end
        @(posedge clk) wr_en <= 1'b0;
    endtask : wr
    // one-cycle read, data taken in the following cycle
    task rd(input logic [1:0] a);
        @(posedge clk) begin addr <= a; rd_en <= 1'b1; end
        @(posedge clk) rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // wait for start (0), done (1) or abort (2), noting wake pulses
    task watch(input int w);
        #1 n = 0;
        woke = wake_request;
        while ((w == 0 ? core_start : w == 1 ? done_flag_set : core_abort) !== 1'b1
               && n < 200) begin
            @(posedge clk) #1 n++;
            woke |= wake_request;
        end
        check("wait", 16'(n < 200), 16'h1);
        repeat (2) @(posedge clk) #1 woke |= wake_request;
    endtask : watch
    // count start pulses over ten cycles
    task quiet(input string what);
        n = 0;
        repeat (10) @(posedge clk) #1 n += int'(core_start === 1'b1);
        check(what, 16'(n), 16'h0);
    endtask : quiet
    // register layout, channel and reference routing
    task t_regs;
        wr(ADDR_CONV_CTRL, 8'hfc); rd(ADDR_CONV_CTRL); check("ctrl", d, 8'h7c);
        wr(ADDR_TRIG_REF, 8'hff); rd(ADDR_TRIG_REF); check("trig", d, 8'h8f);
        for (int c = 0; c < 32; c++) begin
            wr(ADDR_CONV_CTRL, {1'b0, 5'(c), 2'b00});
            @(posedge clk) #1;
            check("chan", core_channel, c <= 27 ? c : 0);
            check("sel", {sel_charge_unit, sel_dac, sel_fixed_ref},
                  {c == 29, c == 30, c == 31});
        end
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_TRIG_REF, {4'h0, 2'(r), 2'(r)});
            @(posedge clk) #1;
            check("pref", pref_route, r == 3 ? 0 : r);
            check("nref", nref_route, r == 1);
        end
        wr(ADDR_TRIG_REF, 8'h00);
    endtask : t_regs
    // software start, completion, result and rc start delay
    task t_soft;
        wr(ADDR_CONV_CTRL, 8'h03); watch(0); n0 = n;
        check("power", core_power, 1'b1);
        rd(ADDR_CONV_CTRL); check("busy", d[1:0], 2'b11);
        watch(1); rd(ADDR_CONV_CTRL); check("idle", d[1:0], 2'b01);
        rd(ADDR_RESULT_HIGH); check("res_hi", d, 8'h02);
        rd(ADDR_RESULT_LOW); check("res_lo", d, 8'ha5);
        @(posedge clk) rc_clock_sel <= 1'b1;
        wr(ADDR_CONV_CTRL, 8'h03); watch(0);
        check("rc_delay", 16'(n - n0), 16'h4);
        watch(1);
        @(posedge clk) rc_clock_sel <= 1'b0;
        wr(ADDR_CONV_CTRL, 8'h03); watch(0);
        @(posedge clk) res_val <= 10'h15a;
        wr(ADDR_CONV_CTRL, 8'h01); watch(2);
        repeat (30) @(posedge clk);
        rd(ADDR_RESULT_LOW); check("kept", d, 8'ha5);
    endtask : t_soft
    // trigger selection, pulse treatment and disabled converter
    task t_trig;
        wr(ADDR_CONV_CTRL, 8'h01);
        @(posedge clk) charge_trigger <= 1'b1;
        quiet("unselected");
        @(posedge clk) compare_trigger <= 1'b1;
        watch(0); rd(ADDR_CONV_CTRL); check("trig_busy", d, 8'h03);
        watch(1); quiet("held");
        @(posedge clk) begin compare_trigger <= 1'b0; charge_trigger <= 1'b0; end
        wr(ADDR_TRIG_REF, 8'h80);
        @(posedge clk) charge_trigger <= 1'b1;
        watch(0); watch(1);
        @(posedge clk) charge_trigger <= 1'b0;
        wr(ADDR_CONV_CTRL, 8'h00);
        @(posedge clk) charge_trigger <= 1'b1;
        quiet("off"); rd(ADDR_CONV_CTRL); check("off", d, 8'h00);
        @(posedge clk) charge_trigger <= 1'b0;
    endtask : t_trig
    // conversions across sleep, then module disable
    task t_sleep;
        @(posedge clk) begin rc_clock_sel <= 1'b1; irq_enable <= 1'b1; end
        wr(ADDR_CONV_CTRL, 8'h03);
        @(posedge clk) sleep_mode <= 1'b1;
        watch(1); check("wake", woke, 1'b1);
        @(posedge clk) begin sleep_mode <= 1'b0; irq_enable <= 1'b0; end
        wr(ADDR_CONV_CTRL, 8'h03);
        @(posedge clk) sleep_mode <= 1'b1;
        watch(1); check("no_wake", woke, 1'b0);
        check("off_pwr", core_power, 1'b0);
        rd(ADDR_CONV_CTRL); check("on_kept", d[0], 1'b1);
        @(posedge clk) begin sleep_mode <= 1'b0; rc_clock_sel <= 1'b0; end
        wr(ADDR_CONV_CTRL, 8'h03); watch(0);
        @(posedge clk) sleep_mode <= 1'b1;
        watch(2); check("abort_pwr", core_power, 1'b0);
        rd(ADDR_CONV_CTRL); check("on_kept2", d[0], 1'b1);
        @(posedge clk) sleep_mode <= 1'b0;
        wr(ADDR_CONV_CTRL, 8'h7d);
        repeat (20) @(posedge clk);  // long settle on the fixed reference channel
        @(posedge clk) module_disable <= 1'b1;
        repeat (2) @(posedge clk) #1;
        check("clk_gate", core_clk_en, 1'b0);
        rd(ADDR_CONV_CTRL); check("held", d, 8'h00);
        @(posedge clk) module_disable <= 1'b0;
        repeat (2) @(posedge clk) #1;
        check("clk_back", core_clk_en, 1'b1);
        rd(ADDR_CONV_CTRL); check("cleared", d, 8'h00);
    endtask : t_sleep
    // verdict and end of run
    task results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_soft;
        t_trig;
        t_sleep;
        results;
    end
    // watchdog against a hang
    initial begin
        #400000;
        num_errors++;
        results;
    end
endmodule : adc_trigger_sleep_control_tb
